// ==== rtl/hsm_pkg.sv ====
// Package of register map, field layout and pin bundle for the power monitor registers
package hsm_pkg;

    // ==========================================================
    // Register indices (low three bits of the command byte)
    // ==========================================================
    localparam logic [2:0] HSM_ADDR_CFG = 3'h0;
    localparam logic [2:0] HSM_ADDR_IRQ = 3'h1;
    localparam logic [2:0] HSM_ADDR_LIVE = 3'h2;
    localparam logic [2:0] HSM_ADDR_FLT = 3'h3;
    localparam logic [2:0] HSM_ADDR_SHUNT = 3'h4;
    localparam logic [2:0] HSM_ADDR_VOUT = 3'h5;

    // ==========================================================
    // Field positions of behaviour_config
    // ==========================================================
    localparam int HSM_CFG_PINFN_HI = 7;
    localparam int HSM_CFG_PINFN_LO = 6;
    localparam int HSM_CFG_ADC_OFF = 5;
    localparam int HSM_CFG_BCAST_EN = 4;
    localparam int HSM_CFG_SWITCH_ON = 3;
    localparam int HSM_CFG_OC_RETRY = 2;
    localparam int HSM_CFG_UV_RETRY = 1;
    localparam int HSM_CFG_OV_RETRY = 0;

    // Pin function codes in config bits 7:6
    localparam logic [1:0] HSM_PINFN_PBAD_INV = 2'h0;
    localparam logic [1:0] HSM_PINFN_PBAD = 2'h2;
    localparam logic [1:0] HSM_PINFN_OUT = 2'h1;
    localparam logic [1:0] HSM_PINFN_IN = 2'h3;

    // ==========================================================
    // Field positions shared by enables, live flags and faults
    // ==========================================================
    localparam int HSM_B_SW_ON = 7;
    localparam int HSM_B_GPIO = 6;
    localparam int HSM_B_SHORT = 5;
    localparam int HSM_B_CARD = 4;
    localparam int HSM_B_PBAD = 3;
    localparam int HSM_B_OC = 2;
    localparam int HSM_B_UV = 1;
    localparam int HSM_B_OV = 0;
    localparam int HSM_NUM_FLT = 6;

    // ==========================================================
    // Reset values and writable masks
    // ==========================================================
    // Bit 2 (overcurrent retry) is filled from the variant parameter
    localparam logic [7:0] HSM_CFG_RST = 8'h13;
    localparam logic [7:0] HSM_IRQ_RST = 8'h00;
    localparam logic [7:0] HSM_IRQ_MASK = 8'h7F;
    localparam logic [7:0] HSM_FLT_MASK = 8'h3F;
    localparam logic [7:0] HSM_ADC_RST = 8'h00;

    // ==========================================================
    // Shunt short threshold: code above 1 mV at 151 uV per step
    // ==========================================================
    localparam int HSM_SHORT_UV = 1000;
    localparam int HSM_SHUNT_LSB_NV = 151000;
    localparam logic [7:0] HSM_SHORT_CODE = 8'((HSM_SHORT_UV * 1000) / HSM_SHUNT_LSB_NV);

    // Pins from outside the clock domain
    typedef struct packed {
        logic switch_req;
        logic card_detect_n;
        logic output_good_sense;
        logic low_input_threshold;
        logic high_input_threshold;
        logic gpio_in;
    } hsm_pins_s;

    localparam int HSM_NUM_PINS = 6;

endpackage

// ==== rtl/hsm_regs.sv ====
// Register bank of the power switch monitor: config, alert enables, live flags, faults, ADC readings
// Functional notes
// RQ1 - Config bits 7:6 pick pin function: inverted power bad, power bad, output, input.
// RQ2 - Config bit 5 set halts ADC conversions; resets to zero.
// RQ3 - Broadcast writes accepted only while config bit 4 is one; resets to one.
// RQ4 - Config bit 3 loads switch request pin at debounce end; drives the switch.
// RQ5 - Config bit 2 picks retry or latch-off after overcurrent; reset per variant.
// RQ6 - Config bit 1 picks retry or latch-off after undervoltage; resets to one.
// RQ7 - Config bit 0 picks retry or latch-off after overvoltage; resets to one.
// RQ8 - Enable bits 5:0 gate alerts per fault, reset zero; bit 7 unused.
// RQ9 - Live bit 7 shows switch on.
// RQ10 - Live bit 5 set while shunt reading exceeds 1 mV with switch off.
// RQ11 - Live bit 4 is one while card detect pin is low.
// RQ12 - Live bit 3 is one while output good sense is low.
// RQ13 - Live bit 2 is one during overcurrent cool-down.
// RQ14 - Live bit 1 is one while low input threshold pin is low.
// RQ15 - Live bit 0 is one while high input threshold is high.
// RQ16 - Fault bit 5 latches suspected switch short; fault bits 7:6 reserved.
// RQ17 - Fault bit 4 latches any card detect pin change.
// RQ18 - Fault bit 3 latches output good sense low.
// RQ19 - Fault bit 2 latches overcurrent fault.
// RQ20 - Fault bit 1 latches low threshold falling; bit 0 high threshold rising.
// RQ21 - Shunt register holds latest 8-bit sense conversion.
// RQ22 - Output voltage register holds latest 8-bit conversion.
// RQ23 - Alert pulled low when an enabled fault bit becomes set.
// RQ24 - Register chosen by low three bits of the command byte.
// RQ25 - Fault bits stay until host writes zero; new alert needs a clear first.
// RQ26 - Reserved bits read zero and ignore writes.
`timescale 1ns/1ps

module hsm_regs #(
    parameter bit OC_RETRY_DEFAULT = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register access from the serial front end
    input wire logic [7:0] cmd_byte,
    input wire logic wr_stb,
    input wire logic wr_bcast,
    input wire logic [7:0] wr_data,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // Alert handshake from the serial front end
    input wire logic alert_release,
    output logic alert_n,
    // Asynchronous pins
    input wire hsm_pkg::hsm_pins_s pins,
    // Power path logic on the same clock
    input wire logic debounce_done,
    input wire logic oc_fault,
    input wire logic oc_cooldown,
    output logic switch_on,
    output logic oc_retry_en,
    output logic uv_retry_en,
    output logic ov_retry_en,
    // Converter
    output logic adc_enable,
    input wire logic adc_valid,
    input wire logic [7:0] adc_shunt_code,
    input wire logic [7:0] adc_vout_code,
    // General purpose pin drive
    output logic gpio_out,
    output logic gpio_oe
);
    import hsm_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [HSM_NUM_PINS-1:0] pin_raw;
    logic [HSM_NUM_PINS-1:0] pin_meta_r;
    logic [HSM_NUM_PINS-1:0] pin_sync_r;
    hsm_pins_s pin_s;

    assign pin_raw = pins;

    // Two stages per pin; only the second stage is read
    genvar gi;
    generate
        for (gi = 0; gi < HSM_NUM_PINS; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    pin_meta_r[gi] <= 1'b0;
                    pin_sync_r[gi] <= 1'b0;
                end else begin
                    pin_meta_r[gi] <= pin_raw[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    assign pin_s = pin_sync_r;

    // Previous synced levels for edge detection
    // Primed only once the synchronisers and the edge history hold real pin levels,
    // since their reset zeros differ from the idle level of some pins
    logic card_prev_r;
    logic uv_prev_r;
    logic ov_prev_r;
    logic [2:0] prime_r;
    wire primed = prime_r[2];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            card_prev_r <= 1'b0;
            uv_prev_r <= 1'b0;
            ov_prev_r <= 1'b0;
            prime_r <= 3'h0;
        end else begin
            card_prev_r <= pin_s.card_detect_n;
            uv_prev_r <= pin_s.low_input_threshold;
            ov_prev_r <= pin_s.high_input_threshold;
            prime_r <= {prime_r[1:0], 1'b1};
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic [7:0] irq_r;
    logic [7:0] irq_nxt;
    logic [7:0] flt_r;
    logic [7:0] flt_nxt;
    logic [7:0] shunt_r;
    logic [7:0] shunt_nxt;
    logic [7:0] vout_r;
    logic [7:0] vout_nxt;
    logic [7:0] rd_data_r;
    logic alert_r;
    logic alert_nxt;

    // Write decode; broadcast writes are dropped unless enabled
    wire [2:0] reg_sel = cmd_byte[2:0]; // see RQ24
    wire wr_ok = wr_stb && (!wr_bcast || cfg_r[HSM_CFG_BCAST_EN]); // see RQ3
    wire wr_cfg = wr_ok && (reg_sel == HSM_ADDR_CFG);
    wire wr_irq = wr_ok && (reg_sel == HSM_ADDR_IRQ);
    wire wr_flt = wr_ok && (reg_sel == HSM_ADDR_FLT);
    wire wr_shunt = wr_ok && (reg_sel == HSM_ADDR_SHUNT);
    wire wr_vout = wr_ok && (reg_sel == HSM_ADDR_VOUT);

    // Pin function decode
    wire [1:0] pin_fn = cfg_r[HSM_CFG_PINFN_HI:HSM_CFG_PINFN_LO];
    wire sw_on = cfg_r[HSM_CFG_SWITCH_ON];

    // ==========================================================
    // Live flags
    // ==========================================================
    wire short_now = (shunt_r > HSM_SHORT_CODE) && !sw_on; // see RQ10
    logic [7:0] live;

    assign live[HSM_B_SW_ON] = sw_on; // see RQ9
    assign live[HSM_B_GPIO] = (pin_fn == HSM_PINFN_IN) ? pin_s.gpio_in : 1'b0; // see RQ1
    assign live[HSM_B_SHORT] = short_now;
    assign live[HSM_B_CARD] = !pin_s.card_detect_n; // see RQ11
    assign live[HSM_B_PBAD] = !pin_s.output_good_sense; // see RQ12
    assign live[HSM_B_OC] = oc_cooldown; // see RQ13
    assign live[HSM_B_UV] = !pin_s.low_input_threshold; // see RQ14
    assign live[HSM_B_OV] = pin_s.high_input_threshold; // see RQ15

    // ==========================================================
    // Fault events; pin-based events wait three cycles after reset to avoid a false start
    // ==========================================================
    logic [7:0] flt_set;

    assign flt_set[7:6] = 2'h0; // see RQ16
    assign flt_set[HSM_B_SHORT] = short_now; // see RQ16
    assign flt_set[HSM_B_CARD] = primed && (pin_s.card_detect_n != card_prev_r); // see RQ17
    assign flt_set[HSM_B_PBAD] = primed && !pin_s.output_good_sense; // see RQ18
    assign flt_set[HSM_B_OC] = oc_fault; // see RQ19
    assign flt_set[HSM_B_UV] = primed && uv_prev_r && !pin_s.low_input_threshold; // see RQ20
    assign flt_set[HSM_B_OV] = primed && !ov_prev_r && pin_s.high_input_threshold; // see RQ20

    // ==========================================================
    // Next-state logic
    // ==========================================================
    // Debounce end overrides the switch bit of a host write in the same cycle: the pin has the final word on bit 3
    always_comb begin
        cfg_nxt = wr_cfg ? wr_data : cfg_r; // see RQ2 RQ5 RQ6 RQ7
        if (debounce_done) begin
            cfg_nxt[HSM_CFG_SWITCH_ON] = pin_s.switch_req; // see RQ4
        end
    end

    assign irq_nxt = wr_irq ? (wr_data & HSM_IRQ_MASK) : irq_r; // see RQ8 RQ26

    // Host can only clear; a new event in the same cycle wins
    assign flt_nxt = ((wr_flt ? (flt_r & wr_data) : flt_r) | flt_set) & HSM_FLT_MASK; // see RQ25 RQ26

    // Conversions land over host writes; only host writes change them while the converter is halted
    assign shunt_nxt = (adc_valid && adc_enable) ? adc_shunt_code : (wr_shunt ? wr_data : shunt_r); // see RQ21
    assign vout_nxt = (adc_valid && adc_enable) ? adc_vout_code : (wr_vout ? wr_data : vout_r); // see RQ22

    // New enabled fault raises alert; release only when nothing new arrives
    wire [7:0] flt_new = flt_set & ~flt_r & HSM_FLT_MASK; // see RQ25
    wire alert_fire = |(flt_new[HSM_NUM_FLT-1:0] & irq_r[HSM_NUM_FLT-1:0]); // see RQ23
    assign alert_nxt = alert_fire ? 1'b1 : (alert_release ? 1'b0 : alert_r);

    // Registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= HSM_CFG_RST | (OC_RETRY_DEFAULT ? 8'h04 : 8'h00); // see RQ5
            irq_r <= HSM_IRQ_RST;
            flt_r <= 8'h00;
            shunt_r <= HSM_ADC_RST;
            vout_r <= HSM_ADC_RST;
            alert_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            irq_r <= irq_nxt;
            flt_r <= flt_nxt;
            shunt_r <= shunt_nxt;
            vout_r <= vout_nxt;
            alert_r <= alert_nxt;
        end
    end

    // ==========================================================
    // Read path; unmapped indices read zero
    // ==========================================================
    logic [7:0] rd_mux;

    always_comb begin
        unique case (reg_sel)
            HSM_ADDR_CFG: rd_mux = cfg_r;
            HSM_ADDR_IRQ: rd_mux = irq_r;
            HSM_ADDR_LIVE: rd_mux = live;
            HSM_ADDR_FLT: rd_mux = flt_r;
            HSM_ADDR_SHUNT: rd_mux = shunt_r;
            HSM_ADDR_VOUT: rd_mux = vout_r;
            default: rd_mux = 8'h00; // see RQ26
        endcase
    end

    // Read data sampled on the strobe and held
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= 8'h00;
        end else if (rd_stb) begin
            rd_data_r <= rd_mux;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign rd_data = rd_data_r;
    assign alert_n = !alert_r;
    assign switch_on = sw_on; // see RQ4
    assign oc_retry_en = cfg_r[HSM_CFG_OC_RETRY]; // see RQ5
    assign uv_retry_en = cfg_r[HSM_CFG_UV_RETRY]; // see RQ6
    assign ov_retry_en = cfg_r[HSM_CFG_OV_RETRY]; // see RQ7
    assign adc_enable = !cfg_r[HSM_CFG_ADC_OFF]; // see RQ2

    // Pin drive per function; input mode releases the pin
    always_comb begin
        unique case (pin_fn)
            HSM_PINFN_PBAD_INV: gpio_out = !live[HSM_B_PBAD]; // see RQ1
            HSM_PINFN_PBAD: gpio_out = live[HSM_B_PBAD];
            HSM_PINFN_OUT: gpio_out = irq_r[HSM_B_GPIO];
            HSM_PINFN_IN: gpio_out = 1'b0;
        endcase
    end
    assign gpio_oe = (pin_fn != HSM_PINFN_IN); // see RQ1

endmodule // hsm_regs

// ==== test/hsm_regs_chk.sv ====
// Checker of the power monitor register bank, bound to its ports
`timescale 1ns/1ps
module hsm_regs_chk
    import hsm_pkg::*;
#(
    parameter bit OC_RETRY_DEFAULT = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] cmd_byte,
    input wire logic wr_stb,
    input wire logic wr_bcast,
    input wire logic [7:0] wr_data,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    // Alert and power path
    input wire logic alert_release,
    input wire logic alert_n,
    input wire logic debounce_done,
    input wire logic switch_on,
    input wire logic oc_retry_en,
    input wire logic uv_retry_en,
    input wire logic ov_retry_en,
    input wire logic adc_enable,
    input wire logic gpio_oe
);
    // ==========================================================
    // Helpers
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Direct config write; broadcast left out since bit 4 is hidden here
    wire cfg_wr = wr_stb && !wr_bcast && cmd_byte[2:0] == HSM_ADDR_CFG;
    wire rd_live = rd_stb && cmd_byte[2:0] == HSM_ADDR_LIVE;
    logic [7:0] wd_r;
    // Delayed write data for next-cycle comparisons
    always_ff @(posedge sys_clk) begin
        wd_r <= wr_data;
    end
    // ==========================================================
    // Properties
    // ==========================================================
    property p_pinfn; cfg_wr |=> gpio_oe == (wd_r[7:6] != HSM_PINFN_IN); endproperty
    a_pinfn: assert property (p_pinfn) else $error("pin drive enable wrong after config write");
    property p_adc; cfg_wr |=> adc_enable == !wd_r[HSM_CFG_ADC_OFF]; endproperty
    a_adc: assert property (p_adc) else $error("converter enable wrong after config write");
    property p_retry; cfg_wr |=> {oc_retry_en, uv_retry_en, ov_retry_en} == wd_r[2:0]; endproperty
    a_retry: assert property (p_retry) else $error("retry enables wrong after config write");
    property p_rst_oc; $rose(rstn) |-> oc_retry_en == OC_RETRY_DEFAULT; endproperty
    a_rst_oc: assert property (p_rst_oc) else $error("overcurrent retry reset value wrong");
    property p_sw; $changed(switch_on) |-> $past(wr_stb) || $past(debounce_done); endproperty
    a_sw: assert property (p_sw) else $error("switch changed without write or debounce");
    property p_rd_hold; !rd_stb |=> $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_rd_none; rd_stb && cmd_byte[2:1] == 2'b11 |=> rd_data == 8'h00; endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped index read not zero");
    property p_flt_rsv; rd_stb && cmd_byte[2:0] == HSM_ADDR_FLT |=> rd_data[7:6] == 2'b00; endproperty
    a_flt_rsv: assert property (p_flt_rsv) else $error("reserved fault bits not zero");
    property p_live_sw; rd_live |=> rd_data[HSM_B_SW_ON] == $past(switch_on); endproperty
    a_live_sw: assert property (p_live_sw) else $error("live switch flag wrong");
    property p_alert_rel; $rose(alert_n) |-> $past(alert_release); endproperty
    a_alert_rel: assert property (p_alert_rel) else $error("alert released without release pulse");
    // Main scenarios reached
    c_cfg: cover property (cfg_wr);
    c_alert: cover property ($fell(alert_n));
    c_live: cover property (rd_live);
endmodule // hsm_regs_chk

bind hsm_regs hsm_regs_chk #(.OC_RETRY_DEFAULT(OC_RETRY_DEFAULT)) chk_u (.sys_clk(sys_clk), .rstn(rstn),
    .cmd_byte(cmd_byte), .wr_stb(wr_stb), .wr_bcast(wr_bcast), .wr_data(wr_data), .rd_stb(rd_stb),
    .rd_data(rd_data), .alert_release(alert_release), .alert_n(alert_n), .debounce_done(debounce_done),
    .switch_on(switch_on), .oc_retry_en(oc_retry_en), .uv_retry_en(uv_retry_en),
    .ov_retry_en(ov_retry_en), .adc_enable(adc_enable), .gpio_oe(gpio_oe));

// ==== test/hsm_host.sv ====
// Host model issuing byte reads and writes on the register port
`timescale 1ns/1ps
module hsm_host (
    // Clock
    sys_clk,
    // Register port
    cmd_byte, wr_stb, wr_bcast, wr_data, rd_stb, rd_data
);
    input wire logic sys_clk;
    output logic [7:0] cmd_byte;
    output logic wr_stb;
    output logic wr_bcast;
    output logic [7:0] wr_data;
    output logic rd_stb;
    input wire logic [7:0] rd_data;
    // ==========================================================
    // Bus cycles
    // ==========================================================
    initial begin
        {cmd_byte, wr_stb, wr_bcast, wr_data, rd_stb} = '0;
    end
    // Idle lines are inverted so stale values never look valid
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic b);
        @(posedge sys_clk);
        #1 {cmd_byte, wr_data, wr_bcast, wr_stb} = {5'h00, a, d, b, 1'b1};
        @(posedge sys_clk);
        #1 {cmd_byte, wr_data, wr_bcast, wr_stb} = {~cmd_byte, ~wr_data, 2'b00};
    endtask
    // Data is registered, so it is taken after the strobe edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1 {cmd_byte, rd_stb} = {5'h00, a, 1'b1};
        @(posedge sys_clk);
        #1 {cmd_byte, rd_stb} = {~cmd_byte, 1'b0};
        d = rd_data;
    endtask
endmodule // hsm_host

// ==== test/hsm_regs_tb.sv ====
// Testbench of the power monitor register bank
`timescale 1ns/1ps
module hsm_regs_tb;
    import hsm_pkg::*;
    typedef struct {logic [2:0] a; logic [7:0] d; logic [7:0] e;} hsm_row_s;
    logic sys_clk, rstn, alert_release, alert_n, debounce_done, oc_fault, oc_cooldown, adc_valid;
    logic switch_on, oc_retry_en, uv_retry_en, ov_retry_en, adc_enable, gpio_out, gpio_oe, wr_stb, wr_bcast, rd_stb;
    logic [7:0] cmd_byte, wr_data, rd_data, adc_shunt_code, adc_vout_code, v;
    logic [4:0] pin_r;
    hsm_pins_s pins;
    int miscompares = 0;
    int cmp_count = 0;
    hsm_row_s rows[7] = '{'{3'h0, 8'h1B, 8'h1B}, '{3'h1, 8'hFF, 8'h7F}, '{3'h4, 8'h5A, 8'h5A},
        '{3'h5, 8'hC3, 8'hC3}, '{3'h3, 8'h00, 8'h00}, '{3'h6, 8'hFF, 8'h00}, '{3'h7, 8'hFF, 8'h00}};
    logic [7:0] gx[4] = '{8'h03, 8'h03, 8'h02, 8'h00};
    // Shared pin pulled up when the block does not drive it
    assign pins = {pin_r, gpio_oe ? gpio_out : 1'b1};
    hsm_regs #(.OC_RETRY_DEFAULT(1'b0)) dut_u (.sys_clk, .rstn, .cmd_byte, .wr_stb, .wr_bcast, .wr_data,
        .rd_stb, .rd_data, .alert_release, .alert_n, .pins, .debounce_done, .oc_fault, .oc_cooldown,
        .switch_on, .oc_retry_en, .uv_retry_en, .ov_retry_en, .adc_enable, .adc_valid, .adc_shunt_code,
        .adc_vout_code, .gpio_out, .gpio_oe);
    hsm_host host_u (.sys_clk, .cmd_byte, .wr_stb, .wr_bcast, .wr_data, .rd_stb, .rd_data);
    // ==========================================================
    // Tasks
    // ==========================================================
    task chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task rdc(input logic [2:0] a, input logic [7:0] e);
        host_u.rd(a, v);
        chk(v, e);
    endtask
    // Inputs change one step after the edge
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and sequence
    // ==========================================================
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Run needs about 110 cycles, so this only cuts a hang
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
    initial begin
        {rstn, alert_release, debounce_done, oc_fault, oc_cooldown, adc_valid} = '0;
        {adc_shunt_code, adc_vout_code} = '0;
        pin_r = 5'b00110;
        cyc(3);
        rstn = 1;
        cyc(4);
        foreach (rows[i]) begin
            host_u.wr(rows[i].a, rows[i].d, 1'b0);
            rdc(rows[i].a, rows[i].e);
        end
        $display("register rows done");
        oc_cooldown = 1;
        rdc(HSM_ADDR_LIVE, 8'h94);
        oc_cooldown = 0;
        pin_r[3] = 1;
        cyc(4);
        chk(8'(alert_n), 8'h00);
        rdc(HSM_ADDR_LIVE, 8'h80);
        rdc(HSM_ADDR_FLT, 8'h10);
        alert_release = 1;
        cyc(1);
        alert_release = 0;
        pin_r[3] = 0;
        cyc(4);
        chk(8'(alert_n), 8'h01);
        host_u.wr(HSM_ADDR_FLT, 8'h00, 1'b0);
        oc_fault = 1;
        cyc(1);
        oc_fault = 0;
        chk(8'(alert_n), 8'h00);
        host_u.wr(HSM_ADDR_FLT, 8'hFF, 1'b0);
        rdc(HSM_ADDR_FLT, 8'h04);
        $display("alert tests done");
        host_u.wr(HSM_ADDR_CFG, 8'h0B, 1'b0);
        host_u.wr(HSM_ADDR_CFG, 8'h1F, 1'b1);
        rdc(HSM_ADDR_CFG, 8'h0B);
        host_u.wr(HSM_ADDR_CFG, 8'h1B, 1'b0);
        host_u.wr(HSM_ADDR_CFG, 8'h13, 1'b1);
        rdc(HSM_ADDR_CFG, 8'h13);
        rdc(HSM_ADDR_LIVE, 8'h30);
        {adc_shunt_code, adc_vout_code, adc_valid} = {8'h06, 8'h77, 1'b1};
        cyc(1);
        adc_valid = 0;
        rdc(HSM_ADDR_LIVE, 8'h10);
        rdc(HSM_ADDR_SHUNT, 8'h06);
        rdc(HSM_ADDR_VOUT, 8'h77);
        rdc(HSM_ADDR_FLT, 8'h24);
        host_u.wr(HSM_ADDR_CFG, 8'h33, 1'b0);
        {adc_shunt_code, adc_valid} = {8'h99, 1'b1};
        cyc(1);
        adc_valid = 0;
        rdc(HSM_ADDR_SHUNT, 8'h06);
        pin_r[4] = 1;
        cyc(3);
        debounce_done = 1;
        cyc(1);
        debounce_done = 0;
        chk(8'(switch_on), 8'h01);
        for (int m = 0; m < 4; m++) begin
            host_u.wr(HSM_ADDR_CFG, {m[1:0], 6'h13}, 1'b0);
            chk(8'({gpio_oe, gpio_out & gpio_oe}), gx[m]);
        end
        cyc(2);
        rdc(HSM_ADDR_LIVE, 8'h50);
        $display("config tests done");
        rstn = 0;
        cyc(3);
        chk(8'({alert_n, switch_on, oc_retry_en, uv_retry_en, ov_retry_en, adc_enable}), 8'h27);
        rstn = 1;
        cyc(1);
        rdc(HSM_ADDR_CFG, 8'h13);
        rdc(HSM_ADDR_IRQ, 8'h00);
        $display("reset tests done");
        summarize();
    end
endmodule // hsm_regs_tb
